// file: core/lsmc_consts.vh
// Purpose: constants of the light sensor measure control block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   definitions only
`ifndef LSMC_CONSTS_VH
`define LSMC_CONSTS_VH

// register indices (word index on the bus)
`define IDX_CHAN_CTRL     10'h040
`define IDX_ITER_COUNT    10'h041
`define IDX_STATUS        10'h042
`define IDX_ALS_DATA      10'h043
`define IDX_ENABLE        10'h080
`define IDX_MODE_A        10'h081
`define IDX_MODE_B        10'h082
`define IDX_FD_SAMPLES_HI 10'h088

// reset values
`define CHAN_CTRL_RST     8'h00
`define ENABLE_RST        8'h00
`define MODE_A_RST        8'h04
`define MODE_B_RST        8'h0C
`define FD_SAMPLES_HI_RST 8'h00
`define ITER_COUNT_RST    8'h01
`define GAIN_STEP_RST     4'h8

// writable bits of sparse registers
`define CHAN_CTRL_MASK     8'h03
`define ENABLE_MASK        8'h43
`define FD_SAMPLES_HI_MASK 8'h87

// bit positions
`define MOD0_OFF_BIT      0
`define MOD1_OFF_BIT      1
`define PON_BIT           0
`define AEN_BIT           1
`define FLICKER_DETECT_ON_BIT          6
`define STOP_COUNT_BIT    7
`define DBL_DROP_BIT      6
`define ONE_SHOT_BIT      5
`define QUEUE_STAT_BIT    4
`define SCALE_MSB         3
`define SCALE_LSB         0
`define END_MARK_BIT      7
`define CHECKSUM_BIT      6
`define QUEUE_GAIN_BIT    5
`define TOP_PLACE_MSB     4
`define TOP_PLACE_LSB     0
`define ENDLESS_BIT       7

// fifo words and gain limits
`define END_MARKER_WORD   8'hFF
`define GAIN_STEP_MAX     4'hF

`endif

// file: core/ahb_reg_port.v
// Purpose: AHB-Lite slave giving byte-wide register access by word index
// Assumes: single whole-word transfers, one slave on the bus
// Notes:   writes take no wait state, reads take one
`timescale 1ns/1ps
module ahb_reg_port (
  input  wire        clk_sys_i,   // system clock
  input  wire        rst_n_i,     // async reset, active low
  input  wire        hsel_i,      // slave select
  input  wire [31:0] haddr_i,     // byte address
  input  wire [1:0]  htrans_i,    // transfer type
  input  wire        hwrite_i,    // write when high
  input  wire [2:0]  hsize_i,     // transfer size, word only
  input  wire [31:0] hwdata_i,    // write data
  input  wire        hready_i,    // bus ready
  output wire        hreadyout_o, // slave ready
  output wire        hresp_o,     // always okay
  output reg  [31:0] hrdata_o,    // read data
  output reg  [9:0]  reg_idx_o,   // register index of data phase
  output wire        wr_en_o,     // write strobe, one cycle
  output wire [7:0]  wr_data_o,   // write byte
  input  wire [7:0]  rd_data_i    // read byte for reg_idx_o
);

  reg  ph_wr_r;
  reg  ph_rd_r;
  wire accept;

  // only nonseq/seq transfers are taken, idle and busy are ignored
  assign accept      = hsel_i & htrans_i[1] & hready_i;
  assign hreadyout_o = ~ph_rd_r;
  assign hresp_o     = 1'b0;
  assign wr_en_o     = ph_wr_r;
  assign wr_data_o   = hwdata_i[7:0];

  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ph_wr_r   <= 1'b0;
      ph_rd_r   <= 1'b0;
      reg_idx_o <= 10'h000;
      hrdata_o  <= 32'h00000000;
    end
    else
    begin
      if (ph_rd_r)
        hrdata_o <= {24'h000000, rd_data_i};
      if (ph_rd_r)
        ph_rd_r <= 1'b0;
      else
        ph_rd_r <= accept & ~hwrite_i;
      ph_wr_r <= accept & hwrite_i;
      if (accept)
        reg_idx_o <= haddr_i[11:2];
    end
  end

endmodule

// file: core/result_scaler.v
// Purpose: picks scaled or unscaled 16-bit view of the 32-bit ambient result
// Assumes: top_i names the most significant used bit of result_i
// Notes:   combinational, the caller registers the outputs
`timescale 1ns/1ps
module result_scaler (
  input  wire [31:0] result_i, // wide ambient result
  input  wire [4:0]  top_i,    // top bit place
  input  wire [3:0]  zeros_i,  // leading bits that must be zero
  output wire [15:0] data_o,   // 16-bit view
  output wire        scaled_o  // scaled view chosen
);

  wire [31:0] aligned;
  wire [31:0] shifted;
  wire [31:0] lead_mask;

  // top bit moved to bit 31 so both views are a plain slice
  assign aligned   = result_i << (5'd31 - top_i);
  assign shifted   = aligned << zeros_i;
  assign lead_mask = ~(32'hFFFFFFFF >> zeros_i);
  assign scaled_o  = ((aligned & lead_mask) == 32'h00000000);
  assign data_o    = scaled_o ? shifted[31:16] : aligned[31:16];

endmodule

// file: core/light_sensor_measure_control.v
// Purpose: control and configuration registers of an ambient light and flicker sensor
// Assumes: measurement engine and result fifo run on clk_sys_i
// Notes:   registers reached over AHB-Lite, byte address = 4 * index
//
// Summary of operation
// - second_modulator_off set keeps modulator 1 idle; clearing lets it run.
// - first_modulator_off set keeps modulator 0 idle; clearing lets it run.
// - writing flicker_detect_on 1 starts flicker detection, 0 stops it.
// - writing ambient_measure_on 1 enables ambient measurement, 0 disables it.
// - power_on_bit set runs the oscillator for timers and modulators.
// - writing power_on_bit 0 stops oscillator and clears both measure enables.
// - stop_after_count ends measurement after iteration count, power stays on.
// - double_gain_drop lowers gain two steps on saturation above step one, one step at step one.
// - one-shot runs one sequencer cycle then asserts sleep_after_irq.
// - queue_ambient_status also queues the ambient status word into fifo.
// - leading result zeros decide scaled or unscaled 16-bit ambient data.
// - 32-bit result register, top bit place selects its msb.
// - end-marker enable appends end marker after each flicker measurement.
// - checksum enable appends flicker checksum after each flicker measurement.
// - queue_gain_word appends current gain after each flicker measurement.
// - endless_flicker_runs repeats flicker runs, no end markers, continuous results.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "lsmc_consts.vh"
module light_sensor_measure_control (
  input  wire        clk_sys_i,        // system clock, 10 MHz
  input  wire        rst_n_i,          // async reset, active low
  input  wire        hsel_i,           // AHB select
  input  wire [31:0] haddr_i,          // AHB address
  input  wire [1:0]  htrans_i,         // AHB transfer type
  input  wire        hwrite_i,         // AHB write
  input  wire [2:0]  hsize_i,          // AHB size
  input  wire [31:0] hwdata_i,         // AHB write data
  input  wire        hready_i,         // AHB ready
  output wire        hreadyout_o,      // AHB slave ready
  output wire        hresp_o,          // AHB response
  output wire [31:0] hrdata_o,         // AHB read data
  input  wire        meas_done_i,      // one measurement iteration done, pulse
  input  wire        seq_cycle_done_i, // sequencer cycle done, pulse
  input  wire        flicker_done_i,   // flicker measurement complete, pulse
  input  wire [7:0]  fd_checksum_i,    // flicker checksum of that measurement
  input  wire        agc_sat_i,        // analogue gain saturation, pulse
  input  wire        agc_raise_i,      // gain control asks one step up, pulse
  input  wire        result_valid_i,   // ambient result ready, pulse
  input  wire [31:0] result_i,         // wide ambient result
  input  wire        fifo_ready_i,     // result fifo accepts a word
  output reg         osc_run_o,        // internal oscillator running
  output reg  [1:0]  mod_run_o,        // modulator channel run enables
  output reg         flicker_run_o,    // flicker detection active
  output reg         ambient_run_o,    // ambient measurement active
  output reg         endless_runs_o,   // repeat flicker sequences forever
  output reg         sleep_after_irq_o,// device put to sleep after one-shot
  output reg  [3:0]  gain_step_o,      // current gain step
  output reg  [15:0] als_data_o,       // 16-bit ambient data
  output reg         fifo_push_o,      // fifo word valid
  output reg  [7:0]  fifo_word_o       // fifo word
);
  localparam [4:0] Q_IDLE = 5'b00001;
  localparam [4:0] Q_STAT = 5'b00010;
  localparam [4:0] Q_GAIN = 5'b00100;
  localparam [4:0] Q_CSUM = 5'b01000;
  localparam [4:0] Q_MARK = 5'b10000;
  wire [9:0]  reg_idx;
  wire        wr_en;
  wire [7:0]  wr_data;
  reg  [7:0]  rd_data;
  wire [15:0] scaled_data;
  wire        scaled_flag;
  reg  [7:0]  chan_ctrl_r;
  reg  [7:0]  enable_r;
  reg  [7:0]  mode_a_r;
  reg  [7:0]  mode_b_r;
  reg  [7:0]  fd_hi_r;
  reg  [7:0]  iter_count_r;
  reg  [7:0]  iter_left_r;
  reg  [7:0]  amb_status_r;
  reg         stat_pend_r;
  reg         fd_pend_r;
  reg  [7:0]  csum_r;
  reg  [4:0]  q_state_r;
  reg  [4:0]  q_state_nxt;
  wire power_on;
  wire fd_on;
  wire amb_on;
  wire stop_hit;
  wire wr_enable;
  function sel;
    input [9:0] idx;
    input [9:0] code;
    begin
      sel = (idx == code);
    end
  endfunction

  ahb_reg_port u_bus (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .hsel_i      (hsel_i),
    .haddr_i     (haddr_i),
    .htrans_i    (htrans_i),
    .hwrite_i    (hwrite_i),
    .hsize_i     (hsize_i),
    .hwdata_i    (hwdata_i),
    .hready_i    (hready_i),
    .hreadyout_o (hreadyout_o),
    .hresp_o     (hresp_o),
    .hrdata_o    (hrdata_o),
    .reg_idx_o   (reg_idx),
    .wr_en_o     (wr_en),
    .wr_data_o   (wr_data),
    .rd_data_i   (rd_data)
  );
  result_scaler u_scale (
    .result_i (result_i),
    .top_i    (mode_b_r[`TOP_PLACE_MSB:`TOP_PLACE_LSB]),
    .zeros_i  (mode_a_r[`SCALE_MSB:`SCALE_LSB]),
    .data_o   (scaled_data),
    .scaled_o (scaled_flag)
  );
  assign power_on  = enable_r[`PON_BIT];
  assign fd_on     = enable_r[`FLICKER_DETECT_ON_BIT];
  assign amb_on    = enable_r[`AEN_BIT];
  assign wr_enable = wr_en & sel(reg_idx, `IDX_ENABLE);
  // last iteration of a counted run; a count of zero acts as one
  assign stop_hit  = meas_done_i & mode_a_r[`STOP_COUNT_BIT] & (fd_on | amb_on) &
                     (iter_left_r <= 8'h01);

  // configuration registers; reserved bits masked off on write
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chan_ctrl_r  <= `CHAN_CTRL_RST;
      mode_a_r     <= `MODE_A_RST;
      mode_b_r     <= `MODE_B_RST;
      fd_hi_r      <= `FD_SAMPLES_HI_RST;
      iter_count_r <= `ITER_COUNT_RST;
    end
    else if (wr_en)
    begin
      if (sel(reg_idx, `IDX_CHAN_CTRL))
        chan_ctrl_r <= wr_data & `CHAN_CTRL_MASK;
      if (sel(reg_idx, `IDX_MODE_A))
        mode_a_r <= wr_data;
      if (sel(reg_idx, `IDX_MODE_B))
        mode_b_r <= wr_data;
      if (sel(reg_idx, `IDX_FD_SAMPLES_HI))
        fd_hi_r <= wr_data & `FD_SAMPLES_HI_MASK;
      if (sel(reg_idx, `IDX_ITER_COUNT))
        iter_count_r <= wr_data;
    end
  end

  // enable register: software write wins over the counted stop
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      enable_r    <= `ENABLE_RST;
      iter_left_r <= `ITER_COUNT_RST;
    end
    else if (wr_enable)
    begin
      iter_left_r <= iter_count_r;
      if (wr_data[`PON_BIT])
        enable_r <= wr_data & `ENABLE_MASK;
      else
        enable_r <= 8'h00;
    end
    else if (stop_hit)
    begin
      enable_r[`FLICKER_DETECT_ON_BIT] <= 1'b0;
      enable_r[`AEN_BIT]  <= 1'b0;
    end
    else if (meas_done_i & mode_a_r[`STOP_COUNT_BIT] & (fd_on | amb_on))
      iter_left_r <= iter_left_r - 8'h01;
  end

  // sleep after a one-shot; the setting event wins over a clearing write
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sleep_after_irq_o <= 1'b0;
    else if (seq_cycle_done_i & mode_a_r[`ONE_SHOT_BIT] & power_on)
      sleep_after_irq_o <= 1'b1;
    else if (wr_enable)
      sleep_after_irq_o <= 1'b0;
  end

  // run enables derived from registers, sleep parks the oscillator
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      osc_run_o      <= 1'b0;
      flicker_run_o  <= 1'b0;
      ambient_run_o  <= 1'b0;
      endless_runs_o <= 1'b0;
    end
    else
    begin
      osc_run_o      <= power_on & ~sleep_after_irq_o;
      flicker_run_o  <= power_on & ~sleep_after_irq_o & fd_on;
      ambient_run_o  <= power_on & ~sleep_after_irq_o & amb_on;
      endless_runs_o <= fd_hi_r[`ENDLESS_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_mod
      always @(posedge clk_sys_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          mod_run_o[g] <= 1'b0;
        else
          mod_run_o[g] <= power_on & ~sleep_after_irq_o & (fd_on | amb_on) &
                          ~chan_ctrl_r[g];
      end
    end
  endgenerate

  // gain step: saturation lowers, raise request lifts, both clamp
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      gain_step_o <= `GAIN_STEP_RST;
    else if (agc_sat_i & (gain_step_o != 4'h0))
    begin
      if (mode_a_r[`DBL_DROP_BIT] & (gain_step_o != 4'h1))
        gain_step_o <= gain_step_o - 4'h2;
      else
        gain_step_o <= gain_step_o - 4'h1;
    end
    else if (agc_raise_i & (gain_step_o != `GAIN_STEP_MAX))
      gain_step_o <= gain_step_o + 4'h1;
  end

  // ambient data and its status word are captured together
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      als_data_o   <= 16'h0000;
      amb_status_r <= 8'h00;
    end
    else if (result_valid_i)
    begin
      als_data_o   <= scaled_data;
      amb_status_r <= {3'h0, scaled_flag, mode_a_r[`SCALE_MSB:`SCALE_LSB]};
    end
  end

  // pending work for the fifo appender; a new event wins over its clear
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stat_pend_r <= 1'b0;
      fd_pend_r   <= 1'b0;
      csum_r      <= 8'h00;
    end
    else
    begin
      if (result_valid_i & mode_a_r[`QUEUE_STAT_BIT])
        stat_pend_r <= 1'b1;
      else if (q_state_r == Q_STAT & fifo_ready_i)
        stat_pend_r <= 1'b0;
      if (flicker_done_i)
      begin
        fd_pend_r <= 1'b1;
        csum_r    <= fd_checksum_i;
      end
      else if (q_state_r == Q_IDLE & ~stat_pend_r)
        fd_pend_r <= 1'b0;
    end
  end

  // appender walks gain, checksum, marker; disabled words are skipped
  always @*
  begin
    q_state_nxt = q_state_r;
    case (q_state_r)
      Q_IDLE:
        if (stat_pend_r)
          q_state_nxt = Q_STAT;
        else if (fd_pend_r)
          q_state_nxt = Q_GAIN;
      Q_STAT:
        if (fifo_ready_i)
          q_state_nxt = Q_IDLE;
      Q_GAIN:
        if (fifo_ready_i | ~mode_b_r[`QUEUE_GAIN_BIT])
          q_state_nxt = Q_CSUM;
      Q_CSUM:
        if (fifo_ready_i | ~mode_b_r[`CHECKSUM_BIT])
          q_state_nxt = Q_MARK;
      Q_MARK:
        if (fifo_ready_i | ~mode_b_r[`END_MARK_BIT] | fd_hi_r[`ENDLESS_BIT])
          q_state_nxt = Q_IDLE;
      default:
        q_state_nxt = Q_IDLE;
    endcase
  end

  // state and fifo word advance together, word taken from the state being entered
  always @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_state_r   <= Q_IDLE;
      fifo_push_o <= 1'b0;
      fifo_word_o <= 8'h00;
    end
    else
    begin
      q_state_r <= q_state_nxt;
      case (q_state_nxt)
        Q_STAT:
        begin
          fifo_push_o <= 1'b1;
          fifo_word_o <= amb_status_r;
        end
        Q_GAIN:
        begin
          fifo_push_o <= mode_b_r[`QUEUE_GAIN_BIT];
          fifo_word_o <= {4'h0, gain_step_o};
        end
        Q_CSUM:
        begin
          fifo_push_o <= mode_b_r[`CHECKSUM_BIT];
          fifo_word_o <= csum_r;
        end
        Q_MARK:
        begin
          fifo_push_o <= mode_b_r[`END_MARK_BIT] & ~fd_hi_r[`ENDLESS_BIT];
          fifo_word_o <= `END_MARKER_WORD;
        end
        default:
        begin
          fifo_push_o <= 1'b0;
          fifo_word_o <= 8'h00;
        end
      endcase
    end
  end

  // read mux; unmapped indices read zero
  always @*
  begin
    rd_data = 8'h00;
    case (reg_idx)
      `IDX_CHAN_CTRL:     rd_data = chan_ctrl_r;
      `IDX_ITER_COUNT:    rd_data = iter_count_r;
      `IDX_STATUS:        rd_data = {gain_step_o, 1'b0, sleep_after_irq_o, amb_status_r[4], osc_run_o};
      `IDX_ALS_DATA:      rd_data = als_data_o[7:0];
      `IDX_ENABLE:        rd_data = enable_r;
      `IDX_MODE_A:        rd_data = mode_a_r;
      `IDX_MODE_B:        rd_data = mode_b_r;
      `IDX_FD_SAMPLES_HI: rd_data = fd_hi_r;
      default:            rd_data = 8'h00;
    endcase
  end

endmodule

// file: test/light_sensor_measure_control_props.sv
// Purpose: concurrent checks on the ports of the measure control block
// Assumes: byte address = 4 * register index, writes take no wait state
// Notes:   bound into every instance of the block
`timescale 1ns/1ps
`include "lsmc_consts.vh"
module lsmc_checker (
  input logic        clk_sys_i, rst_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o,
  input logic        meas_done_i, seq_cycle_done_i, flicker_done_i, agc_sat_i, agc_raise_i,
  input logic        result_valid_i, fifo_ready_i, osc_run_o, flicker_run_o, ambient_run_o,
  input logic        endless_runs_o, sleep_after_irq_o, fifo_push_o,
  input logic [31:0] haddr_i, hwdata_i, hrdata_o, result_i,
  input logic [1:0]  htrans_i, mod_run_o,
  input logic [2:0]  hsize_i,
  input logic [7:0]  fd_checksum_i, fifo_word_o,
  input logic [3:0]  gain_step_o,
  input logic [15:0] als_data_o
);
  logic       dp_act_r;
  logic       dp_wr_r;
  logic [9:0] dp_idx_r;
  wire        chan_wr = dp_act_r && dp_wr_r && hready_i && dp_idx_r == `IDX_CHAN_CTRL;
  wire        en_wr   = dp_act_r && dp_wr_r && hready_i && dp_idx_r == `IDX_ENABLE;
  wire        en_rd   = dp_act_r && !dp_wr_r && hready_i && dp_idx_r == `IDX_ENABLE;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // data phase tracker; held while the slave stretches a read
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dp_act_r <= 1'b0;
      dp_wr_r  <= 1'b0;
      dp_idx_r <= 10'h000;
    end
    else if (hready_i)
    begin
      dp_act_r <= hsel_i && htrans_i[1];
      dp_wr_r  <= hwrite_i;
      dp_idx_r <= haddr_i[11:2];
    end
  end

  AST_MOD1_OFF: assert property (chan_wr && hwdata_i[1] |-> ##2 !mod_run_o[1])
    else $error("modulator 1 runs although switched off");
  AST_MOD0_OFF: assert property (chan_wr && hwdata_i[0] |-> ##2 !mod_run_o[0])
    else $error("modulator 0 runs although switched off");
  AST_FLICKER_EN: assert property (en_wr && hwdata_i[0] && !seq_cycle_done_i
    |-> ##2 flicker_run_o == $past(hwdata_i[6], 2)) else $error("flicker run does not follow enable write");
  AST_AMBIENT_EN: assert property (en_wr && hwdata_i[0] && !seq_cycle_done_i
    |-> ##2 ambient_run_o == $past(hwdata_i[1], 2)) else $error("ambient run does not follow enable write");
  AST_MOD_NEEDS_OSC: assert property (mod_run_o != 2'b00 |-> osc_run_o)
    else $error("modulator runs without oscillator");
  AST_PWR_OFF: assert property (en_wr && !hwdata_i[0]
    |-> ##2 !osc_run_o && !flicker_run_o && !ambient_run_o) else $error("power off left something running");
  AST_GAIN_DROP: assert property (agc_sat_i && gain_step_o != 4'h0 |=> gain_step_o < $past(gain_step_o)
    && {1'b0, gain_step_o} + 5'h02 >= {1'b0, $past(gain_step_o)}) else $error("gain drop out of range");
  AST_RESERVED_ZERO: assert property (en_rd |-> hrdata_o[31:7] == 25'h0 && hrdata_o[5:2] == 4'h0)
    else $error("reserved enable bits read nonzero");
  AST_READ_WAIT: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
    |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait state not exactly one cycle");
endmodule

bind light_sensor_measure_control lsmc_checker i_lsmc_checker (.*);

// file: test/light_sensor_measure_control_tb_top.sv
// Purpose: self-checking bench of the measure control block
// Assumes: AHB-Lite single word transfers, bench is the only master
// Notes:   fifo words are collected by a monitor on push with ready
`timescale 1ns/1ps
`include "lsmc_consts.vh"
module light_sensor_measure_control_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  wire         hready_i;
  wire         hreadyout_o;
  wire         hresp_o;
  wire  [31:0] hrdata_o;
  logic [5:0]  ev = 6'h0;
  logic [7:0]  fd_checksum_i = 8'h0;
  logic [31:0] result_i = 32'h0;
  logic        fifo_ready_i = 1'b1;
  wire         osc_run_o, flicker_run_o, ambient_run_o, endless_runs_o, sleep_after_irq_o, fifo_push_o;
  wire  [1:0]  mod_run_o;
  wire  [3:0]  gain_step_o;
  wire  [15:0] als_data_o;
  wire  [7:0]  fifo_word_o;
  logic [7:0]  fifo_q[$];
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;

  assign hready_i = hreadyout_o;

  light_sensor_measure_control i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .meas_done_i(ev[0]), .seq_cycle_done_i(ev[1]), .flicker_done_i(ev[2]), .fd_checksum_i(fd_checksum_i),
    .agc_sat_i(ev[3]), .agc_raise_i(ev[4]), .result_valid_i(ev[5]), .result_i(result_i),
    .fifo_ready_i(fifo_ready_i), .osc_run_o(osc_run_o), .mod_run_o(mod_run_o), .flicker_run_o(flicker_run_o),
    .ambient_run_o(ambient_run_o), .endless_runs_o(endless_runs_o), .sleep_after_irq_o(sleep_after_irq_o),
    .gain_step_o(gain_step_o), .als_data_o(als_data_o), .fifo_push_o(fifo_push_o), .fifo_word_o(fifo_word_o));

  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // sampled before the edge's own updates land
  always @(posedge clk_sys_i)
  begin
    if (fifo_push_o === 1'b1 && fifo_ready_i === 1'b1)
      fifo_q.push_back(fifo_word_o);
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // address phase held until hready, data phase likewise
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {20'h0, idx, 2'h0};
    hwrite_i <= wr;
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clk_sys_i); while (hready_i !== 1'b1);
    rd = hrdata_o;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, idx, {24'h0, d}, x);
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(x, exp);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge clk_sys_i);
    ev <= m;
    @(posedge clk_sys_i);
    ev <= 6'h0;
  endtask

  task automatic settle;
    repeat (5) @(posedge clk_sys_i);
  endtask

  // bit 16 tells whether the scaled view applies
  function automatic logic [16:0] scale_of(input logic [31:0] r, input int t, input int z);
    logic [31:0] a;
    a = r << (31 - t);
    if ((a >> (32 - z)) == 32'h0)
      return {1'b1, a[31 - z -: 16]};
    return {1'b0, a[31:16]};
  endfunction

  task automatic t_reset_and_reserved;
    rchk(`IDX_CHAN_CTRL, 32'h00);
    rchk(`IDX_ENABLE, 32'h00);
    rchk(`IDX_MODE_A, 32'h04);
    rchk(`IDX_MODE_B, 32'h0C);
    rchk(10'h100, 32'h00);
    chk(gain_step_o, 32'h8);
    chk(hresp_o, 32'h0);
    wr(`IDX_CHAN_CTRL, 8'hFF);
    rchk(`IDX_CHAN_CTRL, 32'h03);
    wr(`IDX_ENABLE, 8'hFF);
    rchk(`IDX_ENABLE, 32'h43);
    settle;
    chk(osc_run_o, 32'h1);
    chk(mod_run_o, 32'h0);
  endtask

  task automatic t_modulators;
    for (int c = 0; c < 4; c++)
    begin
      wr(`IDX_CHAN_CTRL, c[7:0]);
      settle;
      chk(mod_run_o, {30'h0, ~c[1:0]});
    end
  endtask

  task automatic t_enables;
    wr(`IDX_ENABLE, 8'h41);
    settle;
    chk({flicker_run_o, ambient_run_o}, 32'h2);
    wr(`IDX_ENABLE, 8'h03);
    settle;
    chk({flicker_run_o, ambient_run_o}, 32'h1);
    wr(`IDX_ENABLE, 8'h42);
    settle;
    chk({osc_run_o, flicker_run_o, ambient_run_o}, 32'h0);
    rchk(`IDX_ENABLE, 32'h00);
  endtask

  task automatic t_counted_stop;
    wr(`IDX_ITER_COUNT, 8'h03);
    wr(`IDX_MODE_A, 8'h84);
    wr(`IDX_ENABLE, 8'h43);
    pulse(6'h01);
    pulse(6'h01);
    settle;
    chk(ambient_run_o, 32'h1);
    pulse(6'h01);
    settle;
    chk({osc_run_o, flicker_run_o, ambient_run_o}, 32'h4);
    rchk(`IDX_ENABLE, 32'h01);
  endtask

  task automatic t_one_shot_and_gain;
    wr(`IDX_MODE_A, 8'h24);
    wr(`IDX_ENABLE, 8'h03);
    pulse(6'h02);
    settle;
    chk({sleep_after_irq_o, osc_run_o}, 32'h2);
    rchk(`IDX_STATUS, 32'h84);
    wr(`IDX_ENABLE, 8'h03);
    settle;
    chk({sleep_after_irq_o, ambient_run_o}, 32'h1);
    wr(`IDX_MODE_A, 8'h44);
    pulse(6'h08);
    settle;
    chk(gain_step_o, 32'h6);
    wr(`IDX_MODE_A, 8'h04);
    pulse(6'h08);
    settle;
    chk(gain_step_o, 32'h5);
    pulse(6'h10);
    settle;
    chk(gain_step_o, 32'h6);
  endtask

  // far side stalls first, push must stand meanwhile
  task automatic t_fifo_words;
    wr(`IDX_MODE_B, 8'hEC);
    fifo_q.delete();
    fd_checksum_i <= 8'h5A;
    fifo_ready_i <= 1'b0;
    pulse(6'h04);
    settle;
    chk(fifo_push_o, 32'h1);
    fifo_ready_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk(fifo_q.size(), 32'h3);
    chk(fifo_q[0], 32'h06);
    chk(fifo_q[1], 32'h5A);
    chk(fifo_q[2], 32'hFF);
    wr(`IDX_FD_SAMPLES_HI, 8'h80);
    settle;
    chk(endless_runs_o, 32'h1);
    fifo_q.delete();
    pulse(6'h04);
    repeat (8) @(posedge clk_sys_i);
    chk(fifo_q.size(), 32'h2);
    chk(fifo_q[1], 32'h5A);
    wr(`IDX_FD_SAMPLES_HI, 8'h00);
    wr(`IDX_MODE_B, 8'h0C);
  endtask

  task automatic t_scaling;
    logic [31:0] res[2] = '{32'h0000_0123, 32'h0000_1FFF};
    logic [16:0] e;
    wr(`IDX_MODE_A, 8'h14);
    for (int k = 0; k < 2; k++)
    begin
      fifo_q.delete();
      result_i <= res[k];
      pulse(6'h20);
      settle;
      e = scale_of(res[k], 12, 4);
      chk(als_data_o, {16'h0, e[15:0]});
      rchk(`IDX_ALS_DATA, {24'h0, e[7:0]});
      chk(fifo_q.size(), 32'h1);
      chk(fifo_q[0], {27'h0, e[16], 4'h4});
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset_and_reserved;
    t_modulators;
    t_enables;
    t_counted_stop;
    t_one_shot_and_gain;
    t_fifo_words;
    t_scaling;
    tally_and_finish;
  end
endmodule
